// [bench/rtcc_top_chk.sv]
`timescale 1ns/1ps
`include "rtcc_defs.vh"
// ----------------------------------------------------------------
// Port checker for the time and calendar registers
// ----------------------------------------------------------------
module rtcc_top_chk (
  input wire        I_MCLK,
  input wire        I_RST,
  input wire [11:0] I_ADDR,
  input wire [7:0]  I_WDATA,
  input wire        I_WR,
  input wire        I_RD,
  input wire [7:0]  O_RDATA,
  input wire        O_1HZ,
  input wire        O_16HZ,
  input wire        O_TIMER_EN,
  input wire        O_ALARM_EN,
  input wire        O_TIMER_RESET,
  input wire        O_ALARM_RESET
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  // Decoded strobes keep the properties short
  wire rst_wr = I_WR && I_ADDR == `RTCC_ADDR_RST;
  wire pg_wr  = I_WR && I_ADDR == `RTCC_ADDR_PAGE;
  a_rst_reads_zero: assert property (I_RD && I_ADDR == `RTCC_ADDR_RST |=> O_RDATA == 8'h00)
    else $error("reset register read not zero");
  a_page_read_mask: assert property (I_RD && I_ADDR == `RTCC_ADDR_PAGE |=> O_RDATA[7:1] == 7'h00)
    else $error("page write-only bits read back");
  a_sec_top_zero: assert property (I_RD && I_ADDR == `RTCC_ADDR_SEC |=> !O_RDATA[7])
    else $error("seconds top bit not zero");
  a_min_top_zero: assert property (I_RD && I_ADDR == `RTCC_ADDR_MIN |=> !O_RDATA[7])
    else $error("minutes top bit not zero");
  a_timer_rst_pulse: assert property (rst_wr && I_WDATA[5] |=> O_TIMER_RESET)
    else $error("timer reset pulse missing");
  a_alarm_rst_cause: assert property (O_ALARM_RESET |-> $past(rst_wr && I_WDATA[4]))
    else $error("alarm reset pulse without write");
  a_timer_en_set: assert property (pg_wr |=> O_TIMER_EN == $past(I_WDATA[3]))
    else $error("timer enable not taken");
  a_alarm_en_set: assert property (pg_wr |=> O_ALARM_EN == $past(I_WDATA[2]))
    else $error("alarm enable not taken");
  a_gate_one_hz: assert property (rst_wr && I_WDATA[7] ##1 !rst_wr |=> !O_1HZ)
    else $error("1 Hz output not gated");
  a_gate_16_hz: assert property (rst_wr && I_WDATA[6] ##1 !rst_wr |=> !O_16HZ)
    else $error("16 Hz output not gated");
  cover property (rst_wr && I_WDATA[5]);
  cover property (pg_wr && I_WDATA[4]);
  cover property (I_RD && I_ADDR == `RTCC_ADDR_PAGE);
  cover property ($rose(O_1HZ));
endmodule

// [bench/test_rtcc_top.sv]
`timescale 1ns/1ps
`include "rtcc_defs.vh"
// ----------------------------------------------------------------
// Testbench for the time and calendar registers
// ----------------------------------------------------------------
module test_rtcc_top;
  logic        I_MCLK  = 1'b0;
  logic        I_RST   = 1'b1;
  logic [11:0] I_ADDR  = 12'h000;
  logic [7:0]  I_WDATA = 8'h00;
  logic        I_WR    = 1'b0;
  logic        I_RD    = 1'b0;
  wire  [7:0]  O_RDATA;
  wire         O_1HZ, O_16HZ, O_TIMER_EN, O_ALARM_EN, O_TIMER_RESET, O_ALARM_RESET;
  int          fail_count  = 0;
  int          check_count = 0;
  // 25 MHz clock
  always #20 I_MCLK = ~I_MCLK;
  // Short divider so one second is 128 cycles
  rtcc_top #(.DIV32(24'h000004)) dut_u (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_1HZ(O_1HZ),
    .O_16HZ(O_16HZ), .O_TIMER_EN(O_TIMER_EN), .O_ALARM_EN(O_ALARM_EN),
    .O_TIMER_RESET(O_TIMER_RESET), .O_ALARM_RESET(O_ALARM_RESET));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bus cycles start just after an edge; each lets one idle edge pass
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    I_ADDR <= a;
    I_WDATA <= d;
    I_WR <= 1'b1;
    @(posedge I_MCLK);
    I_WR <= 1'b0;
    @(posedge I_MCLK);
  endtask
  // Read data stand only in the cycle after the strobe edge, taken there
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    I_ADDR <= a;
    I_RD <= 1'b1;
    @(posedge I_MCLK);
    I_RD <= 1'b0;
    #1 check($sformatf("reg %h", a), exp, O_RDATA);
    @(posedge I_MCLK);
  endtask
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Reset view of every location, plus an unmapped one
  task automatic t_reset_values;
    logic [7:0] exp [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 9; i++) rd_chk(`RTCC_ADDR_SEC + 12'(i), exp[i]);
    rd_chk(12'h329, 8'h00);
    check("timer enable", 8'h00, {7'h00, O_TIMER_EN});
  endtask
  // All-ones writes show which bits exist; counting is off meanwhile
  task automatic t_masks;
    logic [7:0] msk [7] = '{8'h7F, 8'h7F, 8'h3F, 8'h07, 8'h3F, 8'h1F, 8'hFF};
    for (int i = 0; i < 7; i++) wr(`RTCC_ADDR_SEC + 12'(i), 8'hFF);
    wr(12'h31F, 8'hFF);
    for (int i = 0; i < 7; i++) rd_chk(`RTCC_ADDR_SEC + 12'(i), msk[i]);
    rd_chk(12'h31F, 8'h00);
  endtask
  // Page 1 shows mode and leap setting; write-only bits never read back
  task automatic t_page;
    wr(`RTCC_ADDR_PAGE, 8'h05);
    rd_chk(`RTCC_ADDR_PAGE, 8'h01);
    check("alarm enable", 8'h01, {7'h00, O_ALARM_EN});
    check("timer enable", 8'h00, {7'h00, O_TIMER_EN});
    wr(`RTCC_ADDR_MONTH, 8'hFF);
    wr(`RTCC_ADDR_YEAR, 8'hFF);
    rd_chk(`RTCC_ADDR_MONTH, 8'h01);
    rd_chk(`RTCC_ADDR_YEAR, 8'h03);
    wr(`RTCC_ADDR_PAGE, 8'h00);
    rd_chk(`RTCC_ADDR_MONTH, 8'h1F);
    rd_chk(`RTCC_ADDR_YEAR, 8'hFF);
  endtask
  // Timer and alarm reset pulses last one cycle; pulse seen while it stands
  task automatic t_reset_pulses;
    for (int k = 0; k < 2; k++) begin
      I_ADDR <= `RTCC_ADDR_RST;
      I_WDATA <= (k == 0) ? 8'h20 : 8'h10;
      I_WR <= 1'b1;
      @(posedge I_MCLK);
      I_WR <= 1'b0;
      #1 check("timer reset", (k == 0) ? 8'h01 : 8'h00, {7'h00, O_TIMER_RESET});
      check("alarm reset", (k == 1) ? 8'h01 : 8'h00, {7'h00, O_ALARM_RESET});
      @(posedge I_MCLK);
      #1 check("reset pulse end", 8'h00, {6'h00, O_TIMER_RESET, O_ALARM_RESET});
      @(posedge I_MCLK);
    end
  endtask
  // Full day rollover in 24-hour mode, then output gating while counting
  task automatic t_count_gates;
    logic [1:0] seen1, seen16;
    wr(`RTCC_ADDR_SEC, 8'h59);
    wr(`RTCC_ADDR_MIN, 8'h59);
    wr(`RTCC_ADDR_HOUR, 8'h23);
    wr(`RTCC_ADDR_WDAY, 8'h06);
    wr(`RTCC_ADDR_DATE, 8'h05);
    wr(`RTCC_ADDR_MONTH, 8'h01);
    wr(`RTCC_ADDR_RST, 8'h20);
    wr(`RTCC_ADDR_PAGE, 8'h08);
    #1 check("timer enable", 8'h01, {7'h00, O_TIMER_EN});
    repeat (140) @(posedge I_MCLK);
    rd_chk(`RTCC_ADDR_SEC, 8'h00);
    rd_chk(`RTCC_ADDR_MIN, 8'h00);
    rd_chk(`RTCC_ADDR_HOUR, 8'h00);
    rd_chk(`RTCC_ADDR_WDAY, 8'h00);
    rd_chk(`RTCC_ADDR_DATE, 8'h06);
    seen1 = 2'b00;
    seen16 = 2'b00;
    repeat (300) begin
      @(posedge I_MCLK);
      #1 seen1[O_1HZ] = 1'b1;
      seen16[O_16HZ] = 1'b1;
    end
    check("1 Hz toggles", 8'h03, {6'h00, seen1});
    check("16 Hz toggles", 8'h03, {6'h00, seen16});
    wr(`RTCC_ADDR_RST, 8'hC0);
    repeat (2) @(posedge I_MCLK);
    seen1 = 2'b00;
    repeat (300) begin
      @(posedge I_MCLK);
      #1 seen1 = seen1 | {O_1HZ, O_16HZ};
    end
    check("gated outputs", 8'h00, {6'h00, seen1});
    wr(`RTCC_ADDR_PAGE, 8'h00);
  endtask
  // Adjust rounds seconds to a minute; its carry walks both hour views
  task automatic t_adjust;
    logic [7:0] hr_in  [4] = '{8'h20, 8'h11, 8'h32, 8'h31};
    logic [7:0] hr_exp [4] = '{8'h21, 8'h32, 8'h21, 8'h12};
    wr(`RTCC_ADDR_PAGE, 8'h01);
    wr(`RTCC_ADDR_MONTH, 8'h01);
    wr(`RTCC_ADDR_PAGE, 8'h00);
    wr(`RTCC_ADDR_SEC, 8'h29);
    wr(`RTCC_ADDR_MIN, 8'h10);
    wr(`RTCC_ADDR_PAGE, 8'h10);
    rd_chk(`RTCC_ADDR_SEC, 8'h00);
    rd_chk(`RTCC_ADDR_MIN, 8'h10);
    for (int i = 0; i < 4; i++) begin
      if (i == 1) begin
        wr(`RTCC_ADDR_PAGE, 8'h01);
        wr(`RTCC_ADDR_MONTH, 8'h00);
        wr(`RTCC_ADDR_PAGE, 8'h00);
      end
      wr(`RTCC_ADDR_HOUR, hr_in[i]);
      wr(`RTCC_ADDR_MIN, 8'h59);
      wr(`RTCC_ADDR_SEC, 8'h30);
      wr(`RTCC_ADDR_PAGE, 8'h10);
      rd_chk(`RTCC_ADDR_SEC, 8'h00);
      rd_chk(`RTCC_ADDR_MIN, 8'h00);
      rd_chk(`RTCC_ADDR_HOUR, hr_exp[i]);
    end
    rd_chk(`RTCC_ADDR_DATE, 8'h07);
    rd_chk(`RTCC_ADDR_WDAY, 8'h01);
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge I_MCLK);
    I_RST <= 1'b0;
    @(posedge I_MCLK);
    t_reset_values();
    t_masks();
    t_page();
    t_reset_pulses();
    t_count_gates();
    t_adjust();
    final_report();
  end
  // Watchdog well past the expected run
  initial begin
    repeat (20000) @(posedge I_MCLK);
    fail_count++;
    final_report();
  end
endmodule
bind rtcc_top rtcc_top_chk chk_u (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_ADDR(I_ADDR),
  .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_1HZ(O_1HZ),
  .O_16HZ(O_16HZ), .O_TIMER_EN(O_TIMER_EN), .O_ALARM_EN(O_ALARM_EN),
  .O_TIMER_RESET(O_TIMER_RESET), .O_ALARM_RESET(O_ALARM_RESET));

// [design/rtcc_bcd_inc.v]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Two-digit BCD increment, no wrap limit
// ----------------------------------------------------------------
module rtcc_bcd_inc (
  // Operand
  input  wire [7:0] i_val,
  // Result
  output wire [7:0] o_val
);

  wire [3:0] lo_nxt;
  wire [3:0] hi_nxt;

  // Low digit rolls 9 to 0 and carries into the high digit
  assign lo_nxt = (i_val[3:0] == 4'h9) ? 4'h0 : (i_val[3:0] + 4'h1);
  assign hi_nxt = (i_val[3:0] == 4'h9) ? (i_val[7:4] + 4'h1) : i_val[7:4];
  assign o_val  = {hi_nxt, lo_nxt};

endmodule

// [design/rtcc_defs.vh]
// Behaviour
// - Minutes kept as seven-bit BCD, top bit reads zero.
// - Page 0 month location holds five-bit BCD month, upper bits read zero.
// - Page register write-only bits: adjust, timer enable, alarm enable.
// - Page bit 0 readable, selects calendar view or mode/leap view.
// - Writing 1 resets timer or alarm through the reset register.
// - Gate bits written 0 enable 1 Hz and 16 Hz outputs; low bits written 0.
`ifndef RTCC_DEFS_VH
`define RTCC_DEFS_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define RTCC_ADDR_SEC   12'h320
`define RTCC_ADDR_MIN   12'h321
`define RTCC_ADDR_HOUR  12'h322
`define RTCC_ADDR_WDAY  12'h323
`define RTCC_ADDR_DATE  12'h324
`define RTCC_ADDR_MONTH 12'h325
`define RTCC_ADDR_YEAR  12'h326
`define RTCC_ADDR_PAGE  12'h327
`define RTCC_ADDR_RST   12'h328

// ----------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------
`define RTCC_PAGE_SEL_BIT   0
`define RTCC_ALARM_EN_BIT   2
`define RTCC_TIMER_EN_BIT   3
`define RTCC_ADJUST_BIT     4
`define RTCC_ALARM_RST_BIT  4
`define RTCC_TIMER_RST_BIT  5
`define RTCC_GATE16_BIT     6
`define RTCC_GATE1_BIT      7
`define RTCC_PM_BIT         5
`define RTCC_MASK_SEC       8'h7F
`define RTCC_MASK_MIN       8'h7F
`define RTCC_MASK_HOUR      8'h3F
`define RTCC_MASK_WDAY      8'h07
`define RTCC_MASK_DATE      8'h3F
`define RTCC_MASK_MONTH     8'h1F

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RTCC_RST_SEC    8'h00
`define RTCC_RST_MIN    8'h00
`define RTCC_RST_HOUR   8'h00
`define RTCC_RST_WDAY   8'h00
`define RTCC_RST_DATE   8'h01
`define RTCC_RST_MONTH  8'h01
`define RTCC_RST_YEAR   8'h00
`define RTCC_RST_GATE   1'b1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RTCC_CLK_HZ     25000000
`define RTCC_HALF16_HZ  32
// Clock over 32 Hz, sized to the divider's 24-bit count
`define RTCC_DIV32      24'h0BEBC2

`endif

// [design/rtcc_tick_div.v]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Clock divider giving a one-cycle enable pulse
// ----------------------------------------------------------------
module rtcc_tick_div #(
  parameter [23:0] DIV = 24'h0BEBC2
) (
  // Clock and reset
  input  wire i_clk,
  input  wire i_rst,
  // Synchronous restart
  input  wire i_clr,
  // Enable pulse
  output wire o_tick
);

  reg [23:0] cnt_q;

  // Restart lets a timer reset align the sub-second phase
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 24'h000000;
    end else if (i_clr || (cnt_q == (DIV - 24'h000001))) begin
      cnt_q <= 24'h000000;
    end else begin
      cnt_q <= cnt_q + 24'h000001;
    end
  end

  assign o_tick = (cnt_q == (DIV - 24'h000001)) && !i_clr;

endmodule

// [design/rtcc_top.v]
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "rtcc_defs.vh"
// ----------------------------------------------------------------
// Time and calendar registers
// ----------------------------------------------------------------
module rtcc_top #(
  parameter [23:0] DIV32 = `RTCC_DIV32
) (
  // Clock and reset
  input  wire       I_MCLK,
  input  wire       I_RST,
  // Register port
  input  wire [11:0] I_ADDR,
  input  wire [7:0]  I_WDATA,
  input  wire        I_WR,
  input  wire        I_RD,
  output reg  [7:0]  O_RDATA,
  // Clock outputs
  output reg         O_1HZ,
  output reg         O_16HZ,
  // Timer and alarm control
  output reg         O_TIMER_EN,
  output reg         O_ALARM_EN,
  output reg         O_TIMER_RESET,
  output reg         O_ALARM_RESET
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg  [7:0] sec_q;
  reg  [7:0] min_q;
  reg  [7:0] hour_q;
  reg  [7:0] wday_q;
  reg  [7:0] date_q;
  reg  [7:0] month_q;
  reg  [7:0] year_q;
  reg        page_q;
  reg        mode24_q;
  reg  [1:0] leap_q;
  reg        gate1_q;
  reg        gate16_q;
  reg  [4:0] sub_q;
  reg        sq16_q;

  wire       tick32;
  wire       tick1;
  wire [7:0] sec_inc;
  wire [7:0] min_inc;
  wire [7:0] hour_inc;
  wire [7:0] date_inc;
  wire [7:0] month_inc;
  wire [7:0] year_inc;
  wire [7:0] hour_base;

  wire wr_sec;
  wire wr_min;
  wire wr_hour;
  wire wr_wday;
  wire wr_date;
  wire wr_month;
  wire wr_year;
  wire wr_page;
  wire wr_rst;
  wire timer_clr;
  wire adjust;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Full 12-bit compare, so no alias of these locations answers elsewhere
  // Unmapped addresses fall through every compare and are ignored
  assign wr_sec   = I_WR && (I_ADDR == `RTCC_ADDR_SEC);
  assign wr_min   = I_WR && (I_ADDR == `RTCC_ADDR_MIN);
  assign wr_hour  = I_WR && (I_ADDR == `RTCC_ADDR_HOUR);
  assign wr_wday  = I_WR && (I_ADDR == `RTCC_ADDR_WDAY);
  assign wr_date  = I_WR && (I_ADDR == `RTCC_ADDR_DATE);
  assign wr_month = I_WR && (I_ADDR == `RTCC_ADDR_MONTH);
  assign wr_year  = I_WR && (I_ADDR == `RTCC_ADDR_YEAR);
  assign wr_page  = I_WR && (I_ADDR == `RTCC_ADDR_PAGE);
  assign wr_rst   = I_WR && (I_ADDR == `RTCC_ADDR_RST);

  // Write-only strobes act on the write itself, nothing is stored
  assign timer_clr = wr_rst && I_WDATA[`RTCC_TIMER_RST_BIT];
  assign adjust    = wr_page && I_WDATA[`RTCC_ADJUST_BIT];

  // ----------------------------------------------------------------
  // Sub-second divider: 32 Hz pulses feed both square outputs
  // ----------------------------------------------------------------
  // One divider serves every rate; the 16 Hz and 1 Hz squares are
  // derived from it so their edges always line up with the seconds
  rtcc_tick_div #(
    .DIV (DIV32)
  ) u_div (
    .i_clk  (I_MCLK),
    .i_rst  (I_RST),
    .i_clr  (timer_clr),
    .o_tick (tick32)
  );

  // One second passes when the 5-bit 32 Hz count wraps with the timer enabled
  assign tick1 = tick32 && (sub_q == 5'h1F) && O_TIMER_EN;

  // Sub-count and 16 Hz square keep running with the timer disabled,
  // so the square outputs stay alive while software sets the time
  always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      sub_q  <= 5'h00;
      sq16_q <= 1'b0;
    end else if (timer_clr) begin
      sub_q  <= 5'h00;
      sq16_q <= 1'b0;
    end else if (tick32) begin
      sub_q  <= sub_q + 5'h01;
      sq16_q <= ~sq16_q;
    end
  end

  // ----------------------------------------------------------------
  // BCD incrementers
  // ----------------------------------------------------------------
  // The 24-hour view counts through the 20 h digit; the 12-hour view
  // must not, because bit 5 there is the afternoon flag
  assign hour_base = mode24_q ? hour_q : {3'h0, hour_q[4:0]};

  // Each incrementer only adds one; wrap limits are applied below
  rtcc_bcd_inc u_inc_sec   (.i_val (sec_q),   .o_val (sec_inc));
  rtcc_bcd_inc u_inc_min   (.i_val (min_q),   .o_val (min_inc));
  rtcc_bcd_inc u_inc_hour  (.i_val (hour_base), .o_val (hour_inc));
  rtcc_bcd_inc u_inc_date  (.i_val (date_q),  .o_val (date_inc));
  rtcc_bcd_inc u_inc_month (.i_val (month_q), .o_val (month_inc));
  rtcc_bcd_inc u_inc_year  (.i_val (year_q),  .o_val (year_inc));

  // ----------------------------------------------------------------
  // Carry chain
  // ----------------------------------------------------------------
  // Carries ripple in one cycle from seconds up to years; the chain is
  // short enough at this clock that no pipelining is worth its latency
  reg        c_min;
  reg        c_hour;
  reg        c_day;
  reg        c_month;
  reg        c_year;
  reg  [7:0] last_date;
  reg  [7:0] hour_nxt;

  // Month length depends on the leap counter; zero marks a leap year
  always @* begin
    case (month_q)
      8'h02:   last_date = (leap_q == 2'h0) ? 8'h29 : 8'h28;
      8'h04:   last_date = 8'h30;
      8'h06:   last_date = 8'h30;
      8'h09:   last_date = 8'h30;
      8'h11:   last_date = 8'h30;
      default: last_date = 8'h31;
    endcase
  end

  // Adjust rounds to the nearest minute, so half a minute carries
  always @* begin
    c_min   = (tick1 && (sec_q == 8'h59)) || (adjust && (sec_q >= 8'h30));
    c_hour  = c_min && (min_q == 8'h59);
    c_day   = 1'b0;
    hour_nxt = hour_inc;
    if (mode24_q) begin
      c_day = c_hour && (hour_q == 8'h23);
      if (hour_q == 8'h23) begin
        hour_nxt = 8'h00;
      end
    end else begin
      // 12-hour view: 11 goes to 12 and flips the afternoon flag
      if (hour_q[4:0] == 5'h11) begin
        hour_nxt = {2'h0, ~hour_q[`RTCC_PM_BIT], 5'h12};
        c_day    = c_hour && hour_q[`RTCC_PM_BIT];
      end else if (hour_q[4:0] == 5'h12) begin
        hour_nxt = {2'h0, hour_q[`RTCC_PM_BIT], 5'h01};
      end else begin
        hour_nxt = {2'h0, hour_q[`RTCC_PM_BIT], hour_inc[4:0]};
      end
    end
    c_month = c_day && (date_q == last_date);
    c_year  = c_month && (month_q == 8'h12);
  end

  // ----------------------------------------------------------------
  // Time counters; a software write wins over a carry in that cycle
  // ----------------------------------------------------------------
  // Limitation: digits written outside BCD range are not repaired; they
  // count on until the next compare that happens to match
  always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      sec_q  <= `RTCC_RST_SEC;
      min_q  <= `RTCC_RST_MIN;
      hour_q <= `RTCC_RST_HOUR;
    end else begin
      if (wr_sec) begin
        sec_q <= I_WDATA & `RTCC_MASK_SEC;
      end else if (adjust) begin
        sec_q <= 8'h00;
      end else if (tick1) begin
        sec_q <= (sec_q == 8'h59) ? 8'h00 : sec_inc;
      end
      if (wr_min) begin
        min_q <= I_WDATA & `RTCC_MASK_MIN;
      end else if (c_min) begin
        min_q <= (min_q == 8'h59) ? 8'h00 : min_inc;
      end
      if (wr_hour) begin
        hour_q <= I_WDATA & `RTCC_MASK_HOUR;
      end else if (c_hour) begin
        hour_q <= hour_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Calendar counters
  // ----------------------------------------------------------------
  always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      wday_q  <= `RTCC_RST_WDAY;
      date_q  <= `RTCC_RST_DATE;
      month_q <= `RTCC_RST_MONTH;
      year_q  <= `RTCC_RST_YEAR;
    end else begin
      // Weekday counts 0 to 6 and wraps; its meaning is up to software
      if (wr_wday) begin
        wday_q <= I_WDATA & `RTCC_MASK_WDAY;
      end else if (c_day) begin
        wday_q <= (wday_q == 8'h06) ? 8'h00 : (wday_q + 8'h01);
      end
      // Date wraps to 1 after the month's last day, never to 0
      if (wr_date) begin
        date_q <= I_WDATA & `RTCC_MASK_DATE;
      end else if (c_day) begin
        date_q <= (date_q == last_date) ? 8'h01 : date_inc;
      end
      // Page 1 diverts month and year writes to the settings
      if (wr_month && !page_q) begin
        month_q <= I_WDATA & `RTCC_MASK_MONTH;
      end else if (c_month) begin
        month_q <= (month_q == 8'h12) ? 8'h01 : month_inc;
      end
      if (wr_year && !page_q) begin
        year_q <= I_WDATA;
      end else if (c_year) begin
        year_q <= (year_q == 8'h99) ? 8'h00 : year_inc;
      end
    end
  end

  // ----------------------------------------------------------------
  // Page 1 settings and control bits
  // ----------------------------------------------------------------
  always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      page_q     <= 1'b0;
      mode24_q   <= 1'b0;
      leap_q     <= 2'h0;
      gate1_q    <= `RTCC_RST_GATE;
      gate16_q   <= `RTCC_RST_GATE;
      O_TIMER_EN <= 1'b0;
      O_ALARM_EN <= 1'b0;
    end else begin
      // Every page write rewrites both enables, which is why software
      // must never update this register by read-modify-write
      if (wr_page) begin
        page_q     <= I_WDATA[`RTCC_PAGE_SEL_BIT];
        O_TIMER_EN <= I_WDATA[`RTCC_TIMER_EN_BIT];
        O_ALARM_EN <= I_WDATA[`RTCC_ALARM_EN_BIT];
      end
      if (wr_month && page_q) begin
        mode24_q <= I_WDATA[0];
      end
      // Leap counter steps with the year so it tracks the four-year cycle
      if (wr_year && page_q) begin
        leap_q <= I_WDATA[1:0];
      end else if (c_year) begin
        leap_q <= leap_q + 2'h1;
      end
      // Gates reset to 1 so both squares stay off until software opens them
      if (wr_rst) begin
        gate1_q  <= I_WDATA[`RTCC_GATE1_BIT];
        gate16_q <= I_WDATA[`RTCC_GATE16_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Reset pulses and gated clock outputs
  // ----------------------------------------------------------------
  // Outputs are registered so that gating never glitches the pins
  always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_TIMER_RESET <= 1'b0;
      O_ALARM_RESET <= 1'b0;
      O_1HZ         <= 1'b0;
      O_16HZ        <= 1'b0;
    end else begin
      // Reset requests leave as single-cycle pulses for the timer and alarm
      O_TIMER_RESET <= timer_clr;
      O_ALARM_RESET <= wr_rst && I_WDATA[`RTCC_ALARM_RST_BIT];
      O_1HZ         <= !gate1_q && sub_q[4];
      O_16HZ        <= !gate16_q && sq16_q;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read multiplexer, decoded on the same full address as writes
  reg [7:0] rd_mux;

  // Write-only bits read zero, hence the plain-write discipline
  always @* begin
    case (I_ADDR)
      `RTCC_ADDR_SEC:   rd_mux = sec_q & `RTCC_MASK_SEC;
      `RTCC_ADDR_MIN:   rd_mux = min_q & `RTCC_MASK_MIN;
      `RTCC_ADDR_HOUR:  rd_mux = hour_q & `RTCC_MASK_HOUR;
      `RTCC_ADDR_WDAY:  rd_mux = wday_q & `RTCC_MASK_WDAY;
      `RTCC_ADDR_DATE:  rd_mux = date_q & `RTCC_MASK_DATE;
      `RTCC_ADDR_MONTH: rd_mux = page_q ? {7'h00, mode24_q}
                                        : (month_q & `RTCC_MASK_MONTH);
      `RTCC_ADDR_YEAR:  rd_mux = page_q ? {6'h00, leap_q} : year_q;
      `RTCC_ADDR_PAGE:  rd_mux = {7'h00, page_q};
      default:          rd_mux = 8'h00;
    endcase
  end

  // Data stand only in the cycle after the read strobe
  // Zero between reads keeps an OR-combined read bus quiet
  always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_RDATA <= 8'h00;
    end else if (I_RD) begin
      O_RDATA <= rd_mux;
    end else begin
      O_RDATA <= 8'h00;
    end
  end

endmodule
